// file: hdl/scg_map.svh
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
// ==========================================
// clock operation status layout
`define SCG_CSC_RST 8'hC0
`define SCG_CSC_HS_SYSTEM_CLOCK_STOP_BIT 7
`define SCG_CSC_FIXED_BIT 6
`define SCG_CSC_ONCHIP_HS_OSC_STOP_BIT 0
// ==========================================
// system clock select layout
`define SCG_CKC_MCS_BIT 5
`define SCG_CKC_MCM_BIT 4
`endif

// file: hdl/scg_pkg.sv
package scg_pkg;
  // ==========================================
  // oscillator frequency codes, also the option byte encoding
  typedef enum logic [3:0] {
    SCG_F1 = 4'h0,
    SCG_F2 = 4'h1,
    SCG_F3 = 4'h2,
    SCG_F4 = 4'h3,
    SCG_F6 = 4'h4,
    SCG_F8 = 4'h5,
    SCG_F12 = 4'h6,
    SCG_F16 = 4'h7,
    SCG_F24 = 4'h8,
    SCG_F48 = 4'h9
  } scg_freq_t;
  // ==========================================
  // source switch sequencer
  typedef enum logic [1:0] {
    SCG_SW_RUN = 2'b00,
    SCG_SW_DRAIN = 2'b01,
    SCG_SW_ARM = 2'b10
  } scg_sw_state_t;
endpackage

// file: hdl/scg_sw_if.sv
`timescale 1ns/100ps
interface scg_sw_if;
  logic sel;
  logic ih_tick;
  logic hs_tick;
  logic out_tick;
  logic src;
  logic busy;
  modport mux (input sel, input ih_tick, input hs_tick, output out_tick, output src, output busy);
  modport ctl (output sel, output ih_tick, output hs_tick, input out_tick, input src, input busy);
endinterface

// file: hdl/scg_clk_switch.sv
`timescale 1ns/100ps
module scg_clk_switch
  import scg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  scg_sw_if.mux sw
);
  // ==========================================
  // state
  scg_sw_state_t state_q, state_d;
  logic src_q, src_d;
  logic old_tick, new_tick;

  assign old_tick = src_q ? sw.hs_tick : sw.ih_tick;
  assign new_tick = src_q ? sw.ih_tick : sw.hs_tick;

  always_comb begin
    state_d = state_q;
    src_d = src_q;
    unique case (state_q)
      SCG_SW_RUN: begin
        if (sw.sel != src_q) begin
          state_d = SCG_SW_DRAIN;
        end
      end
      // last old pulse passes whole, then the gate closes
      SCG_SW_DRAIN: begin
        if (old_tick) begin
          state_d = SCG_SW_ARM;
        end
      end
      // output held quiet until a clean new edge
      SCG_SW_ARM: begin
        if (new_tick) begin
          src_d = ~src_q;
          state_d = SCG_SW_RUN;
        end
      end
      default: begin
        state_d = SCG_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= SCG_SW_RUN;
      src_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      src_q <= src_d;
    end
  end

  assign sw.out_tick = (state_q != SCG_SW_ARM) && old_tick;
  assign sw.src = src_q;
  assign sw.busy = state_q != SCG_SW_RUN;

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);

  AST_SRC_FOLLOWS: assert property ((state_q == SCG_SW_RUN) |->
    (sw.out_tick == (src_q ? sw.hs_tick : sw.ih_tick)))
    else $error("output tick not taken from selected source");
  AST_QUIET_GAP: assert property ((state_q == SCG_SW_ARM) |-> !sw.out_tick)
    else $error("tick leaked while switching");
  sequence s_drained;
    (state_q == SCG_SW_DRAIN) && old_tick;
  endsequence
  AST_DRAIN_ARMS: assert property (s_drained |=> (state_q == SCG_SW_ARM) && $stable(src_q))
    else $error("switch did not arm after last old tick");
  AST_SRC_FLIP: assert property ($changed(src_q) |-> $past(state_q) == SCG_SW_ARM)
    else $error("source changed outside arm state");
endmodule

// file: hdl/scg_clock_gen.sv
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_clock_gen
  import scg_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_MAIN_CLOCK_SOURCE_SEL,
  input wire logic I_CSC_WR,
  input wire logic [7:0] I_CSC_DATA,
  input wire logic I_STOP_EXEC,
  input wire logic I_HALT_EXEC,
  input wire logic [3:0] I_OPT_FREQ,
  input wire logic I_FREQ_SEL_WR,
  input wire logic [3:0] I_FREQ_SEL_DATA,
  input wire logic I_WATCHDOG_ENABLE_CFG,
  input wire logic I_WATCHDOG_STANDBY_RUN_CFG,
  input wire logic I_INTERVAL_TIMER_LOWCLK_SEL,
  input wire logic I_EXT_MODE,
  input wire logic I_CRYSTAL_CLOCK,
  input wire logic I_EXTERNAL_CLOCK_INPUT,
  input wire logic I_HOCO_TICK,
  input wire logic I_LOWSPEED_TICK,
  output logic O_MAIN_CLOCK_TICK,
  output logic O_MAIN_CLOCK_SOURCE_STATUS,
  output logic O_SWITCH_BUSY,
  output logic [7:0] O_CSC_VALUE,
  output logic [7:0] O_CKC_VALUE,
  output logic O_XTAL_OSC_EN,
  output logic O_EXTCLK_GATE_EN,
  output logic O_HOCO_EN,
  output logic [3:0] O_HOCO_FREQ,
  output logic O_IH_DIV2,
  output logic O_LOWSPEED_EN,
  output logic O_WDT_LS_TICK,
  output logic O_ITMR_LS_TICK,
  output logic O_TMR_LS_TICK
);
  // ==========================================
  // clock operation status
  localparam logic [7:0] csc_rst = `SCG_CSC_RST;
  logic hs_system_clock_stop_q, hs_system_clock_stop_d;
  logic onchip_hs_osc_stop_q, onchip_hs_osc_stop_d;

  always_comb begin
    hs_system_clock_stop_d = hs_system_clock_stop_q;
    onchip_hs_osc_stop_d = onchip_hs_osc_stop_q;
    if (I_CSC_WR) begin
      hs_system_clock_stop_d = I_CSC_DATA[`SCG_CSC_HS_SYSTEM_CLOCK_STOP_BIT];
      onchip_hs_osc_stop_d = I_CSC_DATA[`SCG_CSC_ONCHIP_HS_OSC_STOP_BIT];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      hs_system_clock_stop_q <= csc_rst[`SCG_CSC_HS_SYSTEM_CLOCK_STOP_BIT];
      onchip_hs_osc_stop_q <= csc_rst[`SCG_CSC_ONCHIP_HS_OSC_STOP_BIT];
    end else if (I_CE) begin
      hs_system_clock_stop_q <= hs_system_clock_stop_d;
      onchip_hs_osc_stop_q <= onchip_hs_osc_stop_d;
    end
  end

  always_comb begin
    O_CSC_VALUE = 8'h00;
    O_CSC_VALUE[`SCG_CSC_HS_SYSTEM_CLOCK_STOP_BIT] = hs_system_clock_stop_q;
    O_CSC_VALUE[`SCG_CSC_FIXED_BIT] = 1'b1;
    O_CSC_VALUE[`SCG_CSC_ONCHIP_HS_OSC_STOP_BIT] = onchip_hs_osc_stop_q;
  end

  // ==========================================
  // oscillator enables and high-speed system clock
  logic hs_tick;
  assign O_XTAL_OSC_EN = !I_STOP_EXEC && !hs_system_clock_stop_q && !I_EXT_MODE;
  assign O_EXTCLK_GATE_EN = !I_STOP_EXEC && !hs_system_clock_stop_q && I_EXT_MODE;
  assign O_HOCO_EN = !I_STOP_EXEC && !onchip_hs_osc_stop_q;
  assign hs_tick = I_EXT_MODE ? (I_EXTERNAL_CLOCK_INPUT && O_EXTCLK_GATE_EN)
                              : (I_CRYSTAL_CLOCK && O_XTAL_OSC_EN);

  // ==========================================
  // on-chip oscillator frequency
  // illegal override codes are dropped so a bad write cannot mistune the oscillator
  logic ovr_valid_q, ovr_valid_d;
  logic [3:0] ovr_freq_q, ovr_freq_d;
  logic half_q, half_d;
  logic ih_tick;

  always_comb begin
    ovr_valid_d = ovr_valid_q;
    ovr_freq_d = ovr_freq_q;
    half_d = half_q;
    if (I_FREQ_SEL_WR && (I_FREQ_SEL_DATA <= SCG_F48)) begin
      ovr_valid_d = 1'b1;
      ovr_freq_d = I_FREQ_SEL_DATA;
    end
    if (O_IH_DIV2 && I_HOCO_TICK && O_HOCO_EN) begin
      half_d = ~half_q;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ovr_valid_q <= 1'b0;
      ovr_freq_q <= 4'h0;
      half_q <= 1'b0;
    end else if (I_CE) begin
      ovr_valid_q <= ovr_valid_d;
      ovr_freq_q <= ovr_freq_d;
      half_q <= half_d;
    end
  end

  assign O_HOCO_FREQ = ovr_valid_q ? ovr_freq_q : I_OPT_FREQ;
  assign O_IH_DIV2 = O_HOCO_FREQ == SCG_F48;
  assign ih_tick = O_HOCO_EN && I_HOCO_TICK && (!O_IH_DIV2 || half_q);

  // ==========================================
  // main clock source switch
  // a stopped old source never drains, so keep both running across a switch
  scg_sw_if sw ();
  assign sw.sel = I_MAIN_CLOCK_SOURCE_SEL;
  assign sw.ih_tick = ih_tick;
  assign sw.hs_tick = hs_tick;

  scg_clk_switch u_switch (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .sw(sw)
  );

  // low-speed clock never enters this path
  assign O_MAIN_CLOCK_TICK = sw.out_tick && I_CE;
  assign O_MAIN_CLOCK_SOURCE_STATUS = sw.src;
  assign O_SWITCH_BUSY = sw.busy;

  always_comb begin
    O_CKC_VALUE = 8'h00;
    O_CKC_VALUE[`SCG_CKC_MCS_BIT] = sw.src;
    O_CKC_VALUE[`SCG_CKC_MCM_BIT] = I_MAIN_CLOCK_SOURCE_SEL;
  end

  // ==========================================
  // low-speed oscillator
  logic ls_sleep;
  assign ls_sleep = (I_HALT_EXEC || I_STOP_EXEC) && I_WATCHDOG_ENABLE_CFG &&
    !I_INTERVAL_TIMER_LOWCLK_SEL && !I_WATCHDOG_STANDBY_RUN_CFG;
  assign O_LOWSPEED_EN = (I_WATCHDOG_ENABLE_CFG || I_INTERVAL_TIMER_LOWCLK_SEL) &&
    !ls_sleep;
  assign O_WDT_LS_TICK = O_LOWSPEED_EN && I_LOWSPEED_TICK && I_CE;
  assign O_ITMR_LS_TICK = O_LOWSPEED_EN && I_LOWSPEED_TICK && I_CE;
  assign O_TMR_LS_TICK = O_LOWSPEED_EN && I_LOWSPEED_TICK && I_CE;

  // ==========================================
  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  AST_CSC_RESET: assert property ($fell(I_RST) |-> O_CSC_VALUE == `SCG_CSC_RST)
    else $error("status register not at reset value");
  AST_START_ONCHIP: assert property ($fell(I_RST) |-> !O_MAIN_CLOCK_SOURCE_STATUS)
    else $error("cpu not started on on-chip oscillator");
  AST_XTAL_STOP: assert property ((I_STOP_EXEC ||
    O_CSC_VALUE[`SCG_CSC_HS_SYSTEM_CLOCK_STOP_BIT]) |-> !O_XTAL_OSC_EN)
    else $error("crystal running while stopped");
  AST_HOCO_STOP: assert property ((I_CE && I_CSC_WR) &&
    I_CSC_DATA[`SCG_CSC_ONCHIP_HS_OSC_STOP_BIT] |=> !O_HOCO_EN)
    else $error("on-chip oscillator still running after stop write");
  AST_EXT_BLOCK: assert property ((I_EXT_MODE && !O_EXTCLK_GATE_EN) |-> !hs_tick)
    else $error("external clock passed while blocked");
  AST_DIV2: assert property ((O_IH_DIV2 && O_HOCO_EN && I_HOCO_TICK && !half_q) |->
    !ih_tick)
    else $error("48 MHz not halved");
  AST_NODIV: assert property ((!O_IH_DIV2 && O_HOCO_EN && I_HOCO_TICK) |-> ih_tick)
    else $error("low frequency wrongly divided");
  AST_FREQ_OVR: assert property ((I_CE && I_FREQ_SEL_WR) &&
    (I_FREQ_SEL_DATA <= SCG_F48) |=> O_HOCO_FREQ == $past(I_FREQ_SEL_DATA))
    else $error("frequency override not applied");
  AST_FREQ_OPT: assert property (!ovr_valid_q |-> O_HOCO_FREQ == I_OPT_FREQ)
    else $error("option frequency not used");
  AST_LS_RUN: assert property ((I_INTERVAL_TIMER_LOWCLK_SEL ||
    (I_WATCHDOG_ENABLE_CFG && !I_HALT_EXEC && !I_STOP_EXEC)) |-> O_LOWSPEED_EN)
    else $error("low-speed oscillator not running");
  AST_LS_SLEEP: assert property ((I_HALT_EXEC || I_STOP_EXEC) &&
    I_WATCHDOG_ENABLE_CFG && !I_INTERVAL_TIMER_LOWCLK_SEL && !I_WATCHDOG_STANDBY_RUN_CFG
    |-> !O_LOWSPEED_EN && !O_WDT_LS_TICK)
    else $error("low-speed clock ran in standby");
  AST_FREQ_REFUSED: assert property ((I_CE && I_FREQ_SEL_WR) &&
    (I_FREQ_SEL_DATA > SCG_F48) |=> $stable(ovr_freq_q) && $stable(ovr_valid_q))
    else $error("illegal frequency code accepted");
  // clock enable low must hold every register, stop bits included
  AST_CE_FREEZE: assert property (!I_CE |=>
    $stable(O_CSC_VALUE) && $stable(ovr_freq_q) && $stable(half_q))
    else $error("state moved while clock enable low");
  AST_HALF_STEP: assert property ((I_CE && O_IH_DIV2) &&
    (O_HOCO_EN && I_HOCO_TICK) |=> half_q != $past(half_q))
    else $error("48 MHz divider did not step");
  AST_STOP_ALL: assert property (I_STOP_EXEC |->
    !O_XTAL_OSC_EN && !O_EXTCLK_GATE_EN && !O_HOCO_EN)
    else $error("a source ran during stop");
  AST_LS_FANOUT: assert property ((O_ITMR_LS_TICK || O_TMR_LS_TICK) |->
    O_WDT_LS_TICK && O_LOWSPEED_EN && I_LOWSPEED_TICK)
    else $error("low-speed taps disagree");
  AST_CKC_STATUS: assert property (O_CKC_VALUE[`SCG_CKC_MCS_BIT] ==
    O_MAIN_CLOCK_SOURCE_STATUS)
    else $error("status bit not the source in use");
  AST_IH_GATED: assert property (!O_HOCO_EN |-> !ih_tick)
    else $error("internal clock ticked with oscillator stopped");
  AST_MAIN_SOURCES: assert property (O_MAIN_CLOCK_TICK |-> (hs_tick || ih_tick))
    else $error("main tick from an unexpected source");
endmodule

// file: verif/scg_xtal_model.sv
`timescale 1ns/100ps
// ==========================================
// resonator and external clock source
module scg_xtal_model (
  input wire logic i_clk,
  input wire logic i_osc_en,
  input wire logic [3:0] i_period,
  output logic o_xtal_tick,
  output logic o_ext_tick
);
  logic [3:0] cnt = 4'h0;
  initial {o_xtal_tick, o_ext_tick} = 2'b00;
  always @(negedge i_clk) begin
    cnt <= (cnt >= i_period) ? 4'h0 : cnt + 4'h1;
    // external source runs free, blocking is inside
    o_ext_tick <= (cnt == 4'h0);
    // resonator is quiet while stopped
    o_xtal_tick <= i_osc_en && (cnt == 4'h0);
  end
endmodule

// file: verif/scg_clock_gen_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module scg_clock_gen_test;
  import scg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sel = 1'b0, cwr = 1'b0, stp = 1'b0, hlt = 1'b0;
  logic fwr = 1'b0, wdt = 1'b0, sb = 1'b0, itm = 1'b0, ext = 1'b0, hoco = 1'b0, lst = 1'b0;
  logic [7:0] cdat = 8'h00;
  logic [3:0] opt = 4'h8, fdat = 4'h0, per = 4'h0;
  logic xt, et, mt, st, busy, xen, xg, hen, div2, lsen, wt, it, tt, els;
  logic [7:0] csc, system_clock_select_reg;
  logic [3:0] frq;
  int checked = 0, num_errors = 0, n;
  always #50 clk = ~clk;
  scg_xtal_model XTAL (.i_clk(clk), .i_osc_en(xen), .i_period(per), .o_xtal_tick(xt),
    .o_ext_tick(et));
  scg_clock_gen DUT (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_MAIN_CLOCK_SOURCE_SEL(sel),
    .I_CSC_WR(cwr), .I_CSC_DATA(cdat), .I_STOP_EXEC(stp), .I_HALT_EXEC(hlt),
    .I_OPT_FREQ(opt), .I_FREQ_SEL_WR(fwr), .I_FREQ_SEL_DATA(fdat),
    .I_WATCHDOG_ENABLE_CFG(wdt), .I_WATCHDOG_STANDBY_RUN_CFG(sb),
    .I_INTERVAL_TIMER_LOWCLK_SEL(itm), .I_EXT_MODE(ext), .I_CRYSTAL_CLOCK(xt),
    .I_EXTERNAL_CLOCK_INPUT(et), .I_HOCO_TICK(hoco), .I_LOWSPEED_TICK(lst),
    .O_MAIN_CLOCK_TICK(mt), .O_MAIN_CLOCK_SOURCE_STATUS(st), .O_SWITCH_BUSY(busy),
    .O_CSC_VALUE(csc), .O_CKC_VALUE(system_clock_select_reg), .O_XTAL_OSC_EN(xen), .O_EXTCLK_GATE_EN(xg),
    .O_HOCO_EN(hen), .O_HOCO_FREQ(frq), .O_IH_DIV2(div2), .O_LOWSPEED_EN(lsen),
    .O_WDT_LS_TICK(wt), .O_ITMR_LS_TICK(it), .O_TMR_LS_TICK(tt));
  // ==========================================
  // drivers, all moves at the falling edge
  task automatic step(input logic h);
    @(negedge clk);
    hoco = h;
    lst = 1'($urandom);
    #10;
  endtask
  task automatic wr(input logic f, input logic [7:0] d);
    @(negedge clk);
    {cdat, fdat, cwr, fwr} = {d, d[3:0], ~f, f};
    @(negedge clk);
    {cwr, fwr} = 2'b00;
    #10;
  endtask
  task automatic summarize;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    num_errors++;
    summarize;
  end
  // ==========================================
  // tests
  initial begin
    static int q[7] = '{0, 3, 5, 6, 7, 8, 9};
    void'($urandom(88));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    #10;
    `CHK("csc", 8'hC0, csc)
    `CHK("src", 1'b0, st)
    `CHK("ckc", 8'h00, system_clock_select_reg)
    `CHK("hen", 1'b1, hen)
    `CHK("xen", 1'b0, xen)
    $display("reset done");
    foreach (q[i]) begin
      step(1'b0);
      opt = q[i][3:0];
      #1;
      `CHK("opt", q[i][3:0], frq)
      `CHK("div", q[i] == 9, div2)
    end
    // codes above 9 come first, so they meet no earlier override
    for (int i = 15; i >= 0; i--) begin
      wr(1'b1, 8'(i));
      `CHK("frq", (i > 9) ? 4'h9 : 4'(i), frq)
    end
    foreach (q[j]) if (q[j] > 7) begin // cpu held on the internal clock at 24 and 48 MHz
      wr(1'b1, 8'(q[j]));
      n = 0;
      repeat (20) begin
        step(1'b1);
        n += int'(mt);
      end
      `CHK("ticks", (q[j] == 9) ? 10 : 20, n)
    end
    wr(1'b1, 8'h08);
    $display("freq done");
    repeat (12) begin
      n = $urandom;
      {stp, ext} = 2'(n >> 8);
      wr(1'b0, 8'(n));
      `CHK("csc", {n[7], 6'h20, n[0]}, csc)
      `CHK("xen", ~n[7] & ~stp & ~ext, xen)
      `CHK("xgate", ~n[7] & ~stp & ext, xg)
      `CHK("hen", ~n[0] & ~stp, hen)
    end
    {stp, ext} = 2'b00;
    wr(1'b0, 8'h40);
    ce = 1'b0;
    wr(1'b0, 8'h81);
    `CHK("frozen", 8'h40, csc)
    ce = 1'b1;
    $display("csc done");
    for (int i = 0; i < 32; i++) begin
      {stp, wdt, itm, sb, hlt} = 5'(i);
      els = (wdt | itm) & ~((hlt | stp) & wdt & ~itm & ~sb);
      step(1'b0);
      `CHK("ls_en", els, lsen)
      `CHK("wdt_tick", lst & els, wt)
      `CHK("itmr_tick", lst & els, it)
      `CHK("tmr_tick", lst & els, tt)
      `CHK("main", 1'b0, mt)
    end
    {stp, hlt} = 2'b00;
    $display("low speed done");
    // prompt then slow resonator, switching there and back each time
    for (int r = 0; r < 2; r++) begin
      per = 4'(r * 5);
      for (int s = 1; s >= 0; s--) begin
        sel = s[0];
        for (int k = 0; k < 200 && st !== sel; k++) step(1'($urandom));
        `CHK("src", sel, st)
        `CHK("busy", 1'b0, busy)
        `CHK("ckc", {2'b00, sel, sel, 4'h0}, system_clock_select_reg)
        repeat (20) begin
          step(1'($urandom));
          `CHK("main", sel ? xt : hoco, mt)
        end
      end
    end
    $display("switch done");
    // reset again while on the system clock, nothing may survive it
    sel = 1'b1;
    for (int k = 0; k < 200 && st !== 1'b1; k++) step(1'($urandom));
    `CHK("src", 1'b1, st)
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    #10;
    `CHK("src", 1'b0, st)
    `CHK("csc", 8'hC0, csc)
    `CHK("frq", opt, frq)
    $display("reset again done");
    summarize;
  end
endmodule
